// [eeprom_bus_regs.svh]
`ifndef EEPROM_BUS_REGS_SVH
`define EEPROM_BUS_REGS_SVH

// ****************************************
// Select byte layout
// ****************************************
`define SEL_TYPE_ARRAY   4'hA
`define SEL_TYPE_IDENT   4'hB
`define SEL_RW_BIT       0
`define SEL_READ         1'h1

// ****************************************
// Address and data fields
// ****************************************
`define ADDR_HI_A10_BIT  2
`define LOCK_DATA_BIT    1
`define ARRAY_ADDR_BITS  12
`define PAGE_BYTES       32
`define ERASED_BYTE      8'hFF

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS    40
`define WRITE_TIME_NS    5000000

`endif

// [eeprom_bus_pkg.sv]
package eeprom_bus_pkg;

	// ****************************************
	// Protocol engine states, one-hot
	// ****************************************
	typedef enum logic [6:0]
	{
		ST_IDLE   = 7'h01,
		ST_DEVSEL = 7'h02,
		ST_ADDRHI = 7'h04,
		ST_ADDRLO = 7'h08,
		ST_WDATA  = 7'h10,
		ST_RDATA  = 7'h20,
		ST_PROG   = 7'h40
	} bus_state_t;

endpackage

// [serial_eeprom_bus_slave.sv]
`timescale 1ns/1ps
`include "eeprom_bus_regs.svh"

// Functional notes
// [R1] Select byte type nibble 1010 reaches the array, 1011 the identification page.
// [R2] Answer a select byte only when its bits b3..b1 match the chip-select inputs.
// [R3] Last select bit is direction: one reads, zero writes.
// [R4] Acknowledge a matching select byte in bit nine; otherwise release and idle.
// [R5] Write select is followed by high then low address byte, each acknowledged.
// [R6] Programming starts only on a Stop right after a data byte acknowledge.
// [R7] After programming the counter points past the last modified byte.
// [R8] While programming, the data line stays released and all requests are ignored.
// [R9] Write-inhibit high: data bytes get no acknowledge and memory stays unchanged.
// [R10] A page write takes 1 to 32 bytes, wrapping within the page.
// [R11] In-page counter advances per data byte, wrapping only its low five bits.
// [R12] Identification write: type 1011, A10 zero, A4..A0 select the byte.
// [R13] Locked identification page: every data byte is refused and nothing changes.
// [R14] Lock: type 1011, A10 one, data bit 1 set; page becomes read-only.
// [R15] Each aligned four-byte group carries a single-error-correcting code; writes rewrite it.
// [R16] Select bytes go unacknowledged while programming and are acknowledged afterwards.
// [R17] Reads ignore write-inhibit; the counter increments after every byte read.
// [R18] After each output byte the master acknowledge is sampled; none ends the read.
// [R19] Random read: address written, repeated Start, read select, one byte out.
// [R20] Current-address read: read select only, byte at counter, counter increments.
// [R21] Acknowledged reads continue on consecutive bytes, wrapping to address zero.
// [R22] Identification read uses random-read framing; A4..A0 give the start byte.
// [R23] Write-inhibit high still acknowledges the select byte and both address bytes.
// [R24] Data is sampled on each rising edge of the bus clock.
// [R25] The array counter is twelve bits wide; higher address bits are ignored.
module serial_eeprom_bus_slave
	import eeprom_bus_pkg::*;
#(
	parameter int WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS
)
(
	input  wire logic clk,              // System clock
	input  wire logic rstn,             // Asynchronous reset, active low
	input  wire logic ce,               // Clock enable, freezes state when low
	input  wire logic sclClk,           // Bus clock from the master
	input  wire logic sdaIn,            // Data line level
	output logic      sdaOut,           // Data line drive value, always low
	output logic      sdaOe,            // Data line pulled low while high
	input  wire logic chipSelectBit2,   // Chip select strap, matched to b3
	input  wire logic chipSelectBit1,   // Chip select strap, matched to b2
	input  wire logic chipSelectBit0,   // Chip select strap, matched to b1
	input  wire logic writeInhibitInput // High blocks all writes
);

	// ****************************************
	// Sizes
	// ****************************************
	localparam int PW = $clog2(`PAGE_BYTES);
	localparam int GROUPS = (1 << `ARRAY_ADDR_BITS) / 4;
	localparam int PAGE_GROUPS = `PAGE_BYTES / 4;
	localparam int CW = $clog2(WRITE_CYCLES + 1);

	typedef struct packed
	{
		bus_state_t              st;
		bus_state_t              nxt;
		logic [3:0]              bitCnt;
		logic [7:0]              shift;
		logic                    ackIt;
		logic                    isIdent;
		logic [`ARRAY_ADDR_BITS-1:0] addr;
		logic                    a10;
		logic [`PAGE_BYTES-1:0]  wrMask;
		logic                    lockReq;
		logic                    identLocked;
		logic [2:0]              progGrp;
		logic                    progWait;
		logic [CW-1:0]           progCnt;
		logic                    sdaOe;
		logic                    sdaOut;
		logic                    sclS1;
		logic                    sclS2;
		logic                    sclS3;
		logic                    sdaS1;
		logic                    sdaS2;
		logic                    sdaS3;
		logic                    togS1;
		logic                    togS2;
		logic                    togS3;
		logic [2:0]              csS1;
		logic [2:0]              csS2;
		logic                    wcS1;
		logic                    wcS2;
	} slave_state_t;

	localparam slave_state_t RESET_STATE = '{st: ST_IDLE, nxt: ST_IDLE, default: '0};

	// ****************************************
	// Code helpers
	// ****************************************
	// Codeword position of a data bit, skipping the power-of-two check positions
	function automatic logic [5:0] eccPos(input int idx);
		logic [5:0] p;
		int n;
		p = 6'h00;
		n = 0;
		for (int k = 3; k < 40; k++)
		begin
			if ((k & (k - 1)) != 0)
			begin
				if (n == idx)
					p = 6'(k);
				n++;
			end
		end
		return p;
	endfunction

	function automatic logic [5:0] eccCode(input logic [31:0] d);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 0; i < 32; i++)
		begin
			if (d[i])
				c = c ^ eccPos(i);
		end
		return c;
	endfunction

	// A syndrome that names a data bit flips it; check-bit errors need no action
	function automatic logic [31:0] eccFix(input logic [37:0] w);
		logic [31:0] d;
		logic [5:0]  syn;
		d = w[31:0];
		syn = eccCode(w[31:0]) ^ w[37:32];
		for (int i = 0; i < 32; i++)
		begin
			if (syn == eccPos(i))
				d[i] = ~d[i];
		end
		return d;
	endfunction

	// ****************************************
	// Storage
	// ****************************************
	logic [37:0] arrMem [GROUPS];
	logic [37:0] idMem [PAGE_GROUPS];
	logic [7:0]  pageBuf [`PAGE_BYTES];

	slave_state_t s;
	slave_state_t n;
	logic [1:0]   rstSync;
	logic         rstnSync;
	logic         linkBit;
	logic         linkToggle;
	logic         bufWe;
	logic [PW-1:0] bufIdx;
	logic [7:0]   bufData;
	logic         memWe;
	logic [31:0]  rdWord;
	logic [7:0]   rdByte;
	logic [31:0]  oldWord;
	logic [31:0]  mergeWord;
	logic [37:0]  newWord;
	logic [3:0]   grpMask;
	logic         sclFall;
	logic         startCond;
	logic         stopCond;
	logic         bitEv;
	logic [7:0]   inByte;
	logic         dataOk;

	// Devices leave the factory erased
	initial
	begin
		for (int g = 0; g < GROUPS; g++)
			arrMem[g] = {eccCode({4{`ERASED_BYTE}}), {4{`ERASED_BYTE}}};
		for (int g = 0; g < PAGE_GROUPS; g++)
			idMem[g] = {eccCode({4{`ERASED_BYTE}}), {4{`ERASED_BYTE}}};
	end

	// ****************************************
	// Reset release
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rstSync <= 2'h0;
		else
			rstSync <= {rstSync[0], 1'b1};
	end
	assign rstnSync = rstSync[1];

	// ****************************************
	// Bus clock domain
	// ****************************************
	// Each rising bus clock edge captures the data bit and flips a toggle;
	// the bit stays put until the next edge, long after the toggle crosses.
	always_ff @(posedge sclClk or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			linkBit <= 1'b0;
			linkToggle <= 1'b0;
		end
		else
		begin
			linkBit <= sdaIn;                           // [R24]
			linkToggle <= ~linkToggle;
		end
	end

	// ****************************************
	// Read and rewrite paths
	// ****************************************
	assign rdWord = eccFix(s.isIdent ? idMem[s.addr[4:2]] : arrMem[s.addr[11:2]]); // [R15]
	assign rdByte = rdWord[8 * s.addr[1:0] +: 8];
	assign oldWord = eccFix(s.isIdent ? idMem[s.progGrp] : arrMem[{s.addr[11:5], s.progGrp}]);
	assign grpMask = s.wrMask[4 * s.progGrp +: 4];

	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			if (grpMask[b])
				mergeWord[8 * b +: 8] = pageBuf[PW'({s.progGrp, 2'(b)})];
			else
				mergeWord[8 * b +: 8] = oldWord[8 * b +: 8];
		end
	end
	assign newWord = {eccCode(mergeWord), mergeWord};   // [R15]

	// ****************************************
	// Event detection
	// ****************************************
	assign sclFall = s.sclS3 & ~s.sclS2;
	assign startCond = s.sclS2 & s.sclS3 & s.sdaS3 & ~s.sdaS2;
	assign stopCond = s.sclS2 & s.sclS3 & ~s.sdaS3 & s.sdaS2;
	assign bitEv = s.togS2 ^ s.togS3;
	assign inByte = {s.shift[6:0], linkBit};
	assign dataOk = ~s.wcS2 & ~(s.isIdent & s.identLocked); // [R9] [R13] [R23]

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		n = s;
		bufWe = 1'b0;
		bufIdx = s.addr[4:0];
		bufData = inByte;
		memWe = 1'b0;

		n.sclS1 = sclClk;
		n.sclS2 = s.sclS1;
		n.sclS3 = s.sclS2;
		n.sdaS1 = sdaIn;
		n.sdaS2 = s.sdaS1;
		n.sdaS3 = s.sdaS2;
		n.togS1 = linkToggle;
		n.togS2 = s.togS1;
		n.togS3 = s.togS2;
		n.csS1 = {chipSelectBit2, chipSelectBit1, chipSelectBit0};
		n.csS2 = s.csS1;
		n.wcS1 = writeInhibitInput;
		n.wcS2 = s.wcS1;
		n.sdaOut = 1'b0;

		if (s.st == ST_PROG)
		begin
			// Bus is ignored entirely, so polling select bytes go unanswered
			n.sdaOe = 1'b0;                            // [R8] [R16]
			if (!s.progWait)
			begin
				memWe = |grpMask;                      // [R15]
				n.progGrp = s.progGrp + 3'h1;
				if (s.progGrp == 3'(PAGE_GROUPS - 1))
					n.progWait = 1'b1;
			end
			else if (s.progCnt == CW'(WRITE_CYCLES - 1))
			begin
				if (s.lockReq)
					n.identLocked = 1'b1;              // [R14]
				n.st = ST_IDLE;                        // [R7]
			end
			else
				n.progCnt = s.progCnt + CW'(1);
		end
		else if (startCond)
		begin
			n.st = ST_DEVSEL;
			n.bitCnt = 4'h0;
			n.sdaOe = 1'b0;
		end
		else if (stopCond)
		begin
			n.sdaOe = 1'b0;
			n.progGrp = 3'h0;
			n.progWait = 1'b0;
			n.progCnt = '0;
			// The clock rise ahead of a Stop counts as one bit, so the tenth slot is count one
			if (s.st == ST_WDATA && s.bitCnt == 4'h1 && (|s.wrMask || s.lockReq))
				n.st = ST_PROG;                        // [R6]
			else
				n.st = ST_IDLE;
		end
		else if (s.st == ST_RDATA)
		begin
			if (bitEv && s.bitCnt < 4'h8)
				n.bitCnt = s.bitCnt + 4'h1;
			else if (bitEv && s.bitCnt == 4'h8)
			begin
				n.addr = s.addr + `ARRAY_ADDR_BITS'(1);  // [R17] [R20] [R21] [R25]
				if (linkBit)
					n.st = ST_IDLE;                    // [R18]
				else
					n.bitCnt = 4'h9;
			end
			else if (sclFall && s.bitCnt == 4'h8)
				n.sdaOe = 1'b0;
			else if (sclFall && s.bitCnt != 4'h0 && s.bitCnt < 4'h8)
			begin
				n.shift = {s.shift[6:0], 1'b0};
				n.sdaOe = ~s.shift[6];
			end
			else if (sclFall && s.bitCnt == 4'h9)
			begin
				n.shift = rdByte;                      // [R21]
				n.sdaOe = ~rdByte[7];
				n.bitCnt = 4'h0;
			end
		end
		else if (s.st != ST_IDLE)
		begin
			if (bitEv && s.bitCnt < 4'h8)
			begin
				n.shift = inByte;
				n.bitCnt = s.bitCnt + 4'h1;
				if (s.bitCnt == 4'h7)
				begin
					n.ackIt = 1'b1;
					unique case (s.st)
						ST_DEVSEL:
						begin
							if ((inByte[7:4] == `SEL_TYPE_ARRAY
								|| inByte[7:4] == `SEL_TYPE_IDENT)    // [R1]
								&& inByte[3:1] == s.csS2)             // [R2]
							begin
								n.isIdent = (inByte[7:4] == `SEL_TYPE_IDENT);
								if (inByte[`SEL_RW_BIT] == `SEL_READ)  // [R3] [R17]
									n.nxt = ST_RDATA;      // [R19] [R20] [R22]
								else
									n.nxt = ST_ADDRHI;
							end
							else
							begin
								n.st = ST_IDLE;            // [R4]
								n.ackIt = 1'b0;
							end
						end
						ST_ADDRHI:
						begin
							// Bits above the array range are dropped
							n.a10 = inByte[`ADDR_HI_A10_BIT];
							n.addr[11:8] = inByte[3:0];    // [R5] [R25]
							n.nxt = ST_ADDRLO;
						end
						ST_ADDRLO:
						begin
							n.addr[7:0] = inByte;          // [R5] [R19] [R22]
							n.nxt = ST_WDATA;
							n.wrMask = '0;
							n.lockReq = 1'b0;
						end
						ST_WDATA:
						begin
							n.nxt = ST_WDATA;
							n.ackIt = dataOk;              // [R9] [R13]
							if (dataOk && s.isIdent && s.a10)
								n.lockReq = s.lockReq | inByte[`LOCK_DATA_BIT]; // [R14]
							else if (dataOk)
							begin
								bufWe = 1'b1;              // [R10] [R12]
								n.wrMask[s.addr[4:0]] = 1'b1;
								n.addr[4:0] = s.addr[4:0] + 5'h01; // [R11]
							end
						end
						default:
							n.st = ST_IDLE;
					endcase
				end
			end
			else if (bitEv && s.bitCnt == 4'h8)
				n.bitCnt = 4'h9;
			else if (sclFall && s.bitCnt == 4'h8)
				n.sdaOe = s.ackIt;                     // [R4] [R5] [R16] [R23]
			else if (sclFall && s.bitCnt == 4'h9)
			begin
				n.bitCnt = 4'h0;
				n.st = s.nxt;
				if (s.nxt == ST_RDATA)
				begin
					n.shift = rdByte;                  // [R19] [R20]
					n.sdaOe = ~rdByte[7];
				end
				else
					n.sdaOe = 1'b0;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge rstnSync)
	begin
		if (!rstnSync)
			s <= RESET_STATE;
		else if (ce)
			s <= n;
	end

	// Memories carry no reset; their content survives like the cells it models
	always @(posedge clk)
	begin
		if (ce && bufWe)
			pageBuf[bufIdx] <= bufData;
		if (ce && memWe)
		begin
			if (s.isIdent)
				idMem[s.progGrp] <= newWord;
			else
				arrMem[{s.addr[11:5], s.progGrp}] <= newWord;
		end
	end

	assign sdaOut = s.sdaOut;
	assign sdaOe = s.sdaOe;

endmodule

// [eeprom_bus_props.sv]
`timescale 1ns/1ps
module eeprom_bus_props
#(
	parameter int WRITE_CYCLES = 125000 // Programming time in clk cycles
)
(
	input wire logic clk,              // System clock
	input wire logic rstn,             // Reset, active low
	input wire logic ce,               // Clock enable
	input wire logic sclClk,           // Bus clock
	input wire logic sdaIn,            // Data line level
	input wire logic sdaOut,           // Drive value
	input wire logic sdaOe,            // Drive enable
	input wire logic chipSelectBit2,   // Strap for b3
	input wire logic chipSelectBit1,   // Strap for b2
	input wire logic chipSelectBit0,   // Strap for b1
	input wire logic writeInhibitInput // Write block
);
	logic        s1, s2, d1, d2, rdF, arr;
	logic [3:0]  nBit;
	logic [2:0]  nByte;
	logic [7:0]  sh;
	logic [31:0] cnt;
	wire logic   rise  = s1 && !s2;
	wire logic   ackSl = rise && nBit == 4'h8;
	wire logic   stopC = s1 && s2 && !d2 && d1;
	// Busy window is shorter than the design's, so it never over-reaches
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			{s1, s2, d1, d2, rdF, arr, nBit, nByte, sh, cnt} <= '0;
		else
		begin
			s1 <= sclClk;
			s2 <= s1;
			d1 <= sdaIn;
			d2 <= d1;
			cnt <= (cnt != 32'h0) ? cnt - 32'h1 : cnt;
			if (stopC && nBit == 4'h1 && nByte >= 3'h4 && !rdF && arr && !writeInhibitInput)
				cnt <= 32'(WRITE_CYCLES);
			if (s1 && s2 && d2 && !d1)
			begin
				nBit <= 4'h0;
				nByte <= 3'h0;
			end
			else if (rise)
			begin
				sh <= {sh[6:0], sdaIn};
				nBit <= ackSl ? 4'h0 : nBit + 4'h1;
				if (ackSl && nByte != 3'h7)
					nByte <= nByte + 3'h1;
				if (ackSl && nByte == 3'h0)
					{rdF, arr} <= {sh[0], sh[7:4] == 4'hA};
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_driveLow; sdaOe |-> !sdaOut; endproperty
	a_driveLow: assert property (p_driveLow) else $error("line driven high");
	property p_holdHigh; s1 && s2 |-> $stable(sdaOe); endproperty
	a_holdHigh: assert property (p_holdHigh) else $error("drive moved, clock high");
	property p_typeAck; ackSl && nByte == 3'h0 && sdaOe |-> sh[7:4] inside {4'hA, 4'hB}; endproperty
	a_typeAck: assert property (p_typeAck) else $error("bad type acked");
	property p_csAck; ackSl && nByte == 3'h0 && sdaOe
		|-> sh[3:1] == {chipSelectBit2, chipSelectBit1, chipSelectBit0}; endproperty
	a_csAck: assert property (p_csAck) else $error("bad chip select acked");
	property p_inhibit; ackSl && nByte >= 3'h3 && !rdF && writeInhibitInput |-> !sdaOe; endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibited data acked");
	property p_quietIn; rise && !ackSl && (!rdF || nByte == 3'h0) |-> !sdaOe; endproperty
	a_quietIn: assert property (p_quietIn) else $error("drive in master bit");
	property p_nackEnd; ackSl && rdF && nByte != 3'h0 && sdaIn |-> ##20 !sdaOe; endproperty
	a_nackEnd: assert property (p_nackEnd) else $error("drive after master nack");
	property p_busy; ackSl && nByte == 3'h0 && cnt != 32'h0 |-> !sdaOe; endproperty
	a_busy: assert property (p_busy) else $error("acked while programming");
	c_selAck: cover property (ackSl && nByte == 3'h0 && sdaOe);
	c_busyPoll: cover property (ackSl && nByte == 3'h0 && cnt != 32'h0);
	c_inhibit: cover property (ackSl && nByte >= 3'h3 && writeInhibitInput && !rdF);
endmodule

// [bus_master_model.sv]
`timescale 1ns/1ps
module bus_master_model
(
	output logic      scl,    // Bus clock, still between frames
	output logic      sdaLow, // High while the master pulls data low
	input  wire logic sda     // Resolved data line
);
	logic lclk = 1'b0;
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
		#7;
		forever #16 lclk = ~lclk;
	end
	task automatic half();
		repeat (16) @(posedge lclk);
	endtask
	// Data moves only while scl is low, so no false Start or Stop appears
	task automatic bitx(input logic b, output logic r);
		sdaLow = !b;
		half();
		scl = 1'b1;
		r = sda;
		half();
		scl = 1'b0;
	endtask
	task automatic start();
		sdaLow = 1'b0;
		half();
		scl = 1'b1;
		half();
		sdaLow = 1'b1;
		half();
		scl = 1'b0;
	endtask
	task automatic stop();
		sdaLow = 1'b1;
		half();
		scl = 1'b1;
		half();
		sdaLow = 1'b0;
		half();
	endtask
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic mAck, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, v[i]);
		bitx(!mAck, r);
	endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`include "eeprom_bus_regs.svh"
module testbench;
	logic        clk  = 1'b0;
	logic        rstn = 1'b0;
	logic [2:0]  cs   = 3'h0;
	logic        wi   = 1'b0;
	logic        scl, mLow, sdaOut, sdaOe;
	wire logic   sda  = !(sdaOe || mLow);
	logic [7:0]  mem [4096];
	logic [7:0]  idp [32];
	logic [11:0] cur;
	int          n_mismatch  = 0;
	int          comparisons = 0;
	int          cyc         = 0;
	initial
	begin
		forever #20 clk = ~clk;
	end
	serial_eeprom_bus_slave #(.WRITE_CYCLES(400)) dut
	(
		.clk(clk), .rstn(rstn), .ce(1'b1), .sclClk(scl), .sdaIn(sda), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .chipSelectBit2(cs[2]), .chipSelectBit1(cs[1]), .chipSelectBit0(cs[0]),
		.writeInhibitInput(wi)
	);
	bus_master_model m (.scl(scl), .sdaLow(mLow), .sda(sda));
	task automatic results();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic sendb(input logic [7:0] v, input logic exp);
		logic a;
		m.wbyte(v, a);
		chk({7'h0, a}, {7'h0, exp});
	endtask
	task automatic addr(input logic [3:0] ty, input logic [7:0] hi, input logic [7:0] lo);
		m.start();
		sendb({ty, cs, 1'b0}, 1'b1);
		sendb(hi, 1'b1);
		sendb(lo, 1'b1);
	endtask
	task automatic wr(input logic [3:0] ty, input logic [7:0] hi, lo, input int n, input logic ok);
		logic [7:0] v;
		logic [4:0] o;
		addr(ty, hi, lo);
		for (int i = 0; i < n; i++)
		begin
			v = 8'($urandom);
			o = lo[4:0] + i[4:0];
			sendb(v, ok);
			if (ok && ty == `SEL_TYPE_IDENT)
				idp[o] = v;
			else if (ok)
				mem[{hi[3:0], lo[7:5], o}] = v;
		end
		cur = {hi[3:0], lo[7:5], o + 5'h1};
		m.stop();
	endtask
	task automatic rd(input logic [3:0] ty, input logic [7:0] hi, lo, input int n);
		logic [7:0]  v;
		logic [11:0] a;
		a = {hi[3:0], lo};
		addr(ty, hi, lo);
		m.start();
		sendb({ty, cs, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			m.rbyte(i < n - 1, v);
			chk(v, ty == `SEL_TYPE_IDENT ? idp[a[4:0]] : mem[a]);
			a++;
		end
		m.stop();
	endtask
	// Current-address read rides on the first acknowledged poll
	task automatic poll(input logic ck);
		logic       a;
		logic [7:0] v;
		m.start();
		m.wbyte({`SEL_TYPE_ARRAY, cs, 1'b1}, a);
		chk({7'h0, a}, 8'h00);
		for (int k = 0; k < 20 && !a; k++)
		begin
			m.start();
			m.wbyte({`SEL_TYPE_ARRAY, cs, 1'b1}, a);
		end
		chk({7'h0, a}, 8'h01);
		m.rbyte(1'b0, v);
		if (ck)
			chk(v, mem[cur]);
		m.stop();
	endtask
	initial
	begin
		logic [7:0] hi, lo;
		void'($urandom(32'h834B));
		foreach (mem[i])
			mem[i] = `ERASED_BYTE;
		foreach (idp[i])
			idp[i] = `ERASED_BYTE;
		cs = 3'($urandom);
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (8) @(posedge clk);
		hi = 8'($urandom);
		lo = {3'($urandom), 5'h1E};
		wr(`SEL_TYPE_ARRAY, hi, lo, 4, 1'b1);
		poll(1'b1);
		// One stored bit of the group holding the first byte is upset; the read must mend it
		dut.arrMem[{hi[3:0], lo[7:2]}][19] ^= 1'b1;
		rd(`SEL_TYPE_ARRAY, hi, lo, 2);
		rd(`SEL_TYPE_ARRAY, hi, {lo[7:5], 5'h00}, 2);
		@(posedge clk);
		#1 wi = 1'b1;
		wr(`SEL_TYPE_ARRAY, hi, lo, 2, 1'b0);
		rd(`SEL_TYPE_ARRAY, hi, lo, 1);
		@(posedge clk);
		#1 wi = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			m.start();
			sendb(i < 3 ? {`SEL_TYPE_ARRAY, cs ^ (3'h1 << i), 1'b0} : {4'h9, cs, 1'b0}, 1'b0);
		end
		m.stop();
		wr(`SEL_TYPE_ARRAY, 8'hFF, 8'hFF, 1, 1'b1);
		poll(1'b1);
		rd(`SEL_TYPE_ARRAY, 8'hFF, 8'hFF, 2);
		wr(`SEL_TYPE_IDENT, 8'hFB, 8'hFC, 2, 1'b1);
		poll(1'b0);
		rd(`SEL_TYPE_IDENT, 8'hFB, 8'hFC, 2);
		addr(`SEL_TYPE_IDENT, 8'h04, 8'h00);
		sendb(8'hFE, 1'b1);
		m.stop();
		poll(1'b0);
		wr(`SEL_TYPE_IDENT, 8'h00, 8'h1C, 1, 1'b0);
		rd(`SEL_TYPE_IDENT, 8'h00, 8'h1C, 2);
		for (int i = 0; i < 2; i++)
		begin
			hi = 8'($urandom);
			lo = 8'($urandom);
			wr(`SEL_TYPE_ARRAY, hi, lo, 1, 1'b1);
			poll(1'b1);
		end
		results();
	end
endmodule
bind serial_eeprom_bus_slave eeprom_bus_props #(.WRITE_CYCLES(WRITE_CYCLES)) props
(
	.clk(clk), .rstn(rstn), .ce(ce), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .chipSelectBit2(chipSelectBit2), .chipSelectBit1(chipSelectBit1),
	.chipSelectBit0(chipSelectBit0), .writeInhibitInput(writeInhibitInput)
);
